// ===== shared/pec_defs.svh
`ifndef PEC_DEFS_SVH
`define PEC_DEFS_SVH
`define PEC_SEQ_W       12
`define PEC_SEQ_MOD     12'hfff
`define PEC_ID_W        16
`define PEC_ADDR_W      32
`define PEC_BUS_W       8
`define PEC_RST_ZERO    1'b0
`define PEC_DUP_LO      12'h801
`define PEC_SEQ_ONE     12'h001
`endif

// ===== shared/pec_pkg.sv
package pec_pkg;
    typedef enum logic [1:0] {
        PEC_RT_ADDR,
        PEC_RT_ID,
        PEC_RT_IMPL,
        PEC_RT_NONE
    } pec_route_t;
endpackage

// ===== verilog/pec_classifier.sv
// What this block does
// R1: address-routed TLP claimed on primary only inside base/limit; secondary always.
// R2: ID-routed TLP claimed on primary in bus range or own BDF; secondary always.
// R3: implicitly routed TLPs are always claimed.
// R4: this port checks its packets on its own, independent of other ports.
// R5: link errors (decode, lock, elastic, deskew) go to correctable processing.
// R6: TLP or DLLP framing violations go to correctable processing.
// R7: physical-layer errors affect every function of the port.
// R8: data-link-layer errors affect every function of the port.
// R9: bad TLP is discarded and correctable processing invoked.
// R10: bad TLP: EDB with LCRC mismatch, bad LCRC, or unexpected non-duplicate seq.
// R11: DLLP with bad LCRC is discarded and correctable processing invoked.
// R12: replay timeout and replay count rollover invoke correctable processing only.
// R13: protocol error when ack/nak seq matches neither unacked TLP nor acked seq.
// R14: protocol error discards the DLLP and invokes uncorrectable processing.
// R15: surprise link down invokes uncorrectable processing.
// R16: data-link errors suppressed when physical layer flagged the same packet.
// R17: transaction errors suppressed when physical or data-link flagged the packet.
`include "pec_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pec_classifier (
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     pkt_valid_i,
    input  wire logic                     pkt_is_tlp_i,
    input  wire logic                     pkt_primary_i,
    input  wire pec_pkg::pec_route_t      pkt_route_i,
    input  wire logic [`PEC_ADDR_W-1:0]   pkt_addr_i,
    input  wire logic [`PEC_ID_W-1:0]     pkt_dest_id_i,
    input  wire logic [`PEC_ADDR_W-1:0]   win_base_i,
    input  wire logic [`PEC_ADDR_W-1:0]   win_limit_i,
    input  wire logic [`PEC_BUS_W-1:0]    sec_bus_i,
    input  wire logic [`PEC_BUS_W-1:0]    sub_bus_i,
    input  wire logic [`PEC_ID_W-1:0]     own_id_i,
    input  wire logic                     phy_link_err_i,
    input  wire logic                     phy_frame_err_i,
    input  wire logic                     pkt_edb_i,
    input  wire logic                     lcrc_ok_i,
    input  wire logic                     lcrc_inv_ok_i,
    input  wire logic [`PEC_SEQ_W-1:0]    pkt_seq_i,
    input  wire logic [`PEC_SEQ_W-1:0]    next_rcv_seq_i,
    input  wire logic                     pkt_is_acknak_i,
    input  wire logic [`PEC_SEQ_W-1:0]    acked_seq_i,
    input  wire logic [`PEC_SEQ_W-1:0]    next_tx_seq_i,
    input  wire logic                     tl_err_i,
    input  wire logic                     replay_timeout_i,
    input  wire logic                     replay_rollover_i,
    input  wire logic                     surprise_down_i,
    output logic                          claim_o,
    output logic                          discard_o,
    output logic                          corr_o,
    output logic                          uncorr_o,
    output logic                          all_func_o,
    output logic                          tl_err_o
);
    logic rst_meta;
    logic rst_sync;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= `PEC_RST_ZERO;
            rst_sync <= `PEC_RST_ZERO;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // seq a lies in (lo, hi] modulo the sequence space
    function automatic logic seq_in(input logic [`PEC_SEQ_W-1:0] a,
                                    input logic [`PEC_SEQ_W-1:0] lo,
                                    input logic [`PEC_SEQ_W-1:0] hi);
        logic [`PEC_SEQ_W-1:0] da;
        logic [`PEC_SEQ_W-1:0] dh;
        da = (a - lo) & `PEC_SEQ_MOD;
        dh = (hi - lo) & `PEC_SEQ_MOD;
        seq_in = (da != '0) && (da <= dh);
    endfunction

    logic next_claim;
    logic next_discard;
    logic next_corr;
    logic next_uncorr;
    logic next_all_func;
    logic next_tl_err;
    logic phy_err;
    logic dll_err;
    logic dll_corr;
    logic proto_err;
    logic bad_tlp;
    logic dup;
    logic in_bus;

    always_comb begin
        next_claim = 1'b0;
        in_bus = (pkt_dest_id_i[`PEC_ID_W-1 -: `PEC_BUS_W] >= sec_bus_i) &&
                 (pkt_dest_id_i[`PEC_ID_W-1 -: `PEC_BUS_W] <= sub_bus_i);
        if (pkt_valid_i && pkt_is_tlp_i) begin
            case (pkt_route_i)
                pec_pkg::PEC_RT_ADDR: next_claim = !pkt_primary_i ||
                    ((pkt_addr_i >= win_base_i) &&
                     (pkt_addr_i <= win_limit_i)); // R1
                pec_pkg::PEC_RT_ID: next_claim = !pkt_primary_i || in_bus ||
                    (pkt_dest_id_i == own_id_i); // R2
                pec_pkg::PEC_RT_IMPL: next_claim = 1'b1; // R3
                default: next_claim = 1'b0;
            endcase
        end
    end

    // duplicate: an already-received sequence, i.e. behind next_rcv_seq
    always_comb begin
        phy_err = phy_link_err_i || phy_frame_err_i; // R5 R6
        // open low end: the window is the 2048 values just below next_rcv
        dup = seq_in(pkt_seq_i, next_rcv_seq_i - `PEC_DUP_LO,
                     next_rcv_seq_i - `PEC_SEQ_ONE); // R10
        bad_tlp = pkt_valid_i && pkt_is_tlp_i &&
                  ((pkt_edb_i && !lcrc_inv_ok_i) ||
                   (!pkt_edb_i && !lcrc_ok_i) ||
                   ((pkt_seq_i != next_rcv_seq_i) && !dup)); // R10
        proto_err = pkt_valid_i && !pkt_is_tlp_i && pkt_is_acknak_i &&
                    lcrc_ok_i && (pkt_seq_i != acked_seq_i) &&
                    !seq_in(pkt_seq_i, acked_seq_i,
                            next_tx_seq_i - `PEC_SEQ_ONE); // R13
        // phy-flagged packets mask link-layer faults to avoid double reports
        dll_corr = !phy_err && (bad_tlp ||
                   (pkt_valid_i && !pkt_is_tlp_i && !lcrc_ok_i)); // R16 R11
        dll_err = !phy_err && (dll_corr || proto_err); // R16
        next_discard = dll_err; // R9 R11 R14
        next_corr = phy_err || dll_corr ||
                    replay_timeout_i || replay_rollover_i; // R9 R12
        next_uncorr = (dll_err && proto_err) || surprise_down_i; // R14 R15
        next_all_func = next_corr || next_uncorr; // R7 R8
        next_tl_err = tl_err_i && !phy_err && !dll_err; // R17
    end

    // per-port state only, nothing shared with other ports
    always_ff @(posedge clk_i or negedge rst_sync) begin // R4
        if (!rst_sync) begin
            claim_o    <= `PEC_RST_ZERO;
            discard_o  <= `PEC_RST_ZERO;
            corr_o     <= `PEC_RST_ZERO;
            uncorr_o   <= `PEC_RST_ZERO;
            all_func_o <= `PEC_RST_ZERO;
            tl_err_o   <= `PEC_RST_ZERO;
        end else begin
            claim_o    <= next_claim;
            discard_o  <= next_discard;
            corr_o     <= next_corr;
            uncorr_o   <= next_uncorr;
            all_func_o <= next_all_func;
            tl_err_o   <= next_tl_err;
        end
    end

    a_impl_claim: assert property (@(posedge clk_i) disable iff (!rst_sync)
        pkt_valid_i && pkt_is_tlp_i && pkt_route_i == pec_pkg::PEC_RT_IMPL
        |=> claim_o) else $error("implicit tlp not claimed"); // R3
    a_sec_claim: assert property (@(posedge clk_i) disable iff (!rst_sync)
        pkt_valid_i && pkt_is_tlp_i && !pkt_primary_i &&
        pkt_route_i != pec_pkg::PEC_RT_NONE
        |=> claim_o) else $error("secondary tlp not claimed"); // R1
    a_link_corr: assert property (@(posedge clk_i) disable iff (!rst_sync)
        phy_link_err_i |=> corr_o && all_func_o)
        else $error("link error not correctable"); // R5
    a_frame_corr: assert property (@(posedge clk_i) disable iff (!rst_sync)
        phy_frame_err_i |=> corr_o && !discard_o)
        else $error("frame error mishandled"); // R6
    a_down_uncorr: assert property (@(posedge clk_i) disable iff (!rst_sync)
        surprise_down_i |=> uncorr_o && all_func_o)
        else $error("link down not uncorrectable"); // R15
    a_replay_corr: assert property (@(posedge clk_i) disable iff (!rst_sync)
        (replay_timeout_i || replay_rollover_i) && !pkt_valid_i
        |=> corr_o && !discard_o) else $error("replay event wrong"); // R12
    a_phy_mask: assert property (@(posedge clk_i) disable iff (!rst_sync)
        phy_err |=> !discard_o && !tl_err_o && !$past(surprise_down_i) ==
        !uncorr_o) else $error("phy error not masking"); // R16
    a_tl_mask: assert property (@(posedge clk_i) disable iff (!rst_sync)
        tl_err_o |-> !$past(dll_err) && !$past(phy_err))
        else $error("tl error not suppressed"); // R17
    a_bad_lcrc: assert property (@(posedge clk_i) disable iff (!rst_sync)
        pkt_valid_i && !pkt_is_tlp_i && !lcrc_ok_i && !phy_err
        |=> discard_o && corr_o) else $error("bad dllp kept"); // R11
    a_proto_unc: assert property (@(posedge clk_i) disable iff (!rst_sync)
        proto_err && !phy_err |=> discard_o && uncorr_o)
        else $error("protocol error mishandled"); // R14

    c_bad_tlp:  cover property (@(posedge clk_i) bad_tlp && !phy_err);
    c_proto:    cover property (@(posedge clk_i) proto_err);
    c_claim_id: cover property (@(posedge clk_i) next_claim &&
                    pkt_route_i == pec_pkg::PEC_RT_ID && pkt_primary_i);
    c_tl_err:   cover property (@(posedge clk_i) tl_err_o);
endmodule
`default_nettype wire

// ===== tb/pec_link_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "pec_defs.svh"
// far end sequence state, held still so rows can name exact seq values
module pec_link_model #(
    parameter logic [`PEC_SEQ_W-1:0] RCV_SEQ = 12'h100,
    parameter logic [`PEC_SEQ_W-1:0] ACK_SEQ = 12'h050,
    parameter logic [`PEC_SEQ_W-1:0] TX_SEQ  = 12'h060
) (
    output logic [`PEC_SEQ_W-1:0] next_rcv_seq_o,
    output logic [`PEC_SEQ_W-1:0] acked_seq_o,
    output logic [`PEC_SEQ_W-1:0] next_tx_seq_o
);
    assign next_rcv_seq_o = RCV_SEQ;
    assign acked_seq_o    = ACK_SEQ;
    assign next_tx_seq_o  = TX_SEQ;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pec_defs.svh"
module tb_top;
    localparam pec_pkg::pec_route_t ra = pec_pkg::PEC_RT_ADDR;
    localparam pec_pkg::pec_route_t ri = pec_pkg::PEC_RT_ID;
    localparam pec_pkg::pec_route_t rm = pec_pkg::PEC_RT_IMPL;
    localparam pec_pkg::pec_route_t rn = pec_pkg::PEC_RT_NONE;
    typedef struct packed {
        logic v, t, p, k, x;
        pec_pkg::pec_route_t r;
        logic a;
        logic [1:0] d;
        logic [2:0] c;
        logic [4:0] ev;
        logic [11:0] s;
        logic [5:0] y;
    } pec_row_t;
    // c = edb, lcrc ok, inverted ok; ev = link, frame, timeout, roll, down
    pec_row_t rows[25] = '{
        '{1,1,1,0,0,ra,1,0,3'h2,5'h0,12'h100,6'h20},
        '{1,1,1,0,0,ra,0,0,3'h2,5'h0,12'h100,6'h00},
        '{1,1,0,0,0,ra,0,0,3'h2,5'h0,12'h100,6'h20},
        '{1,1,1,0,0,ri,0,1,3'h2,5'h0,12'h100,6'h20},
        '{1,1,1,0,0,ri,0,0,3'h2,5'h0,12'h100,6'h00},
        '{1,1,1,0,0,ri,0,2,3'h2,5'h0,12'h100,6'h20},
        '{1,1,0,0,0,ri,0,0,3'h2,5'h0,12'h100,6'h20},
        '{1,1,1,0,0,rm,0,0,3'h2,5'h0,12'h100,6'h20},
        '{1,1,0,0,0,rm,0,0,3'h2,5'h0,12'h100,6'h20},
        '{1,1,1,0,0,rn,0,0,3'h2,5'h0,12'h0ff,6'h00},
        '{1,1,1,0,0,rn,0,0,3'h2,5'h0,12'h101,6'h1a},
        '{1,1,1,0,0,rn,0,0,3'h0,5'h0,12'h100,6'h1a},
        '{1,1,1,0,0,rn,0,0,3'h6,5'h0,12'h100,6'h1a},
        '{1,1,1,0,1,rn,0,0,3'h2,5'h0,12'h100,6'h01},
        '{1,1,1,0,1,rn,0,0,3'h0,5'h0,12'h100,6'h1a},
        '{1,1,1,0,1,rn,0,0,3'h2,5'h08,12'h100,6'h0a},
        '{0,0,0,0,0,rn,0,0,3'h2,5'h10,12'h100,6'h0a},
        '{1,0,0,0,0,rn,0,0,3'h0,5'h0,12'h100,6'h1a},
        '{1,0,0,1,0,rn,0,0,3'h2,5'h0,12'h055,6'h00},
        '{1,0,0,1,0,rn,0,0,3'h2,5'h0,12'h050,6'h00},
        '{1,0,0,1,0,rn,0,0,3'h2,5'h0,12'h070,6'h16},
        '{1,0,0,1,0,rn,0,0,3'h2,5'h08,12'h070,6'h0a},
        '{0,0,0,0,0,rn,0,0,3'h2,5'h04,12'h100,6'h0a},
        '{0,0,0,0,0,rn,0,0,3'h2,5'h02,12'h100,6'h0a},
        '{0,0,0,0,0,rn,0,0,3'h2,5'h01,12'h100,6'h06}};
    logic clk_i, resetn_i, v, t, p, k, x, e, l, i, pl, pf, rt, rr, sd;
    logic claim, disc, corr, uncorr, allf, tle;
    pec_pkg::pec_route_t r;
    logic [31:0] addr;
    logic [15:0] did;
    logic [11:0] seq, nrs, aks, nts;
    int fails = 0, compares = 0, cycles = 0;
    pec_link_model link (.next_rcv_seq_o(nrs), .acked_seq_o(aks),
        .next_tx_seq_o(nts));
    pec_classifier dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .pkt_valid_i(v), .pkt_is_tlp_i(t), .pkt_primary_i(p),
        .pkt_route_i(r), .pkt_addr_i(addr), .pkt_dest_id_i(did),
        .win_base_i(32'h0000_1000), .win_limit_i(32'h0000_1fff),
        .sec_bus_i(8'h10), .sub_bus_i(8'h1f), .own_id_i(16'h4208),
        .phy_link_err_i(pl), .phy_frame_err_i(pf), .pkt_edb_i(e),
        .lcrc_ok_i(l), .lcrc_inv_ok_i(i), .pkt_seq_i(seq),
        .next_rcv_seq_i(nrs), .pkt_is_acknak_i(k), .acked_seq_i(aks),
        .next_tx_seq_i(nts), .tl_err_i(x), .replay_timeout_i(rt),
        .replay_rollover_i(rr), .surprise_down_i(sd), .claim_o(claim),
        .discard_o(disc), .corr_o(corr), .uncorr_o(uncorr),
        .all_func_o(allf), .tl_err_o(tle));
    task automatic drive(input pec_row_t w);
        {v, t, p, k, x, r, {e, l, i}, {pl, pf, rt, rr, sd}} =
            {w.v, w.t, w.p, w.k, w.x, w.r, w.c, w.ev};
        addr = w.a ? 32'h0000_1800 : 32'h0000_3000;
        did = w.d == 2'h2 ? 16'h4208 : (w.d == 2'h1 ? 16'h1500 : 16'h4000);
        seq = w.s;
    endtask
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // ceiling well above the ~50 cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        resetn_i = 1'b0;
        drive(rows[24]);
        repeat (16) @(posedge clk_i);
        #5 resetn_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #5;
        // back to back packets, one per cycle
        foreach (rows[n]) begin
            drive(rows[n]);
            @(posedge clk_i);
            #5 check({claim, disc, corr, uncorr, allf, tle}, rows[n].y);
        end
        drive(rows[9]);
        @(posedge clk_i);
        #5 check({claim, disc, corr, uncorr, allf, tle}, 6'h00);
        seq = 12'h900;
        @(posedge clk_i);
        #5 check({claim, disc, corr, uncorr, allf, tle}, 6'h00);
        seq = 12'h8ff;
        @(posedge clk_i);
        #5 check({claim, disc, corr, uncorr, allf, tle}, 6'h1a);
        $display("test rows done");
        drive(rows[11]);
        resetn_i = 1'b0;
        @(posedge clk_i);
        #5 check({claim, disc, corr, uncorr, allf, tle}, 6'h00);
        resetn_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #5 check({claim, disc, corr, uncorr, allf, tle}, 6'h00);
        @(posedge clk_i);
        #5 check({claim, disc, corr, uncorr, allf, tle}, 6'h1a);
        $display("test reset done");
        test_done();
    end
endmodule
`default_nettype wire
